// ===== core/tspd_config_bank.sv
// configuration word bank with lock detector and lock pin routing
`timescale 1ns/1ns
module tspd_config_bank
   import tspd_pkg::*;
(
   input  wire logic                 clk_in,         // 100 MHz clock
   input  wire logic                 rst_n_in,       // async reset, active low
   input  wire logic [ADDR_W-1:0]    addr_in,        // word address
   input  wire logic [WORD_W-1:0]    wdata_in,       // write data
   input  wire logic                 wr_in,          // write strobe
   input  wire logic                 rd_in,          // read strobe
   output logic      [WORD_W-1:0]    rdata_out,      // read data, cycle after strobe
   input  wire logic                 ref_clk_in,     // reference divider output pin
   input  wire logic                 vco_div_in,     // divided oscillator phase
   input  wire logic                 synth_mon_in,   // synth test monitor signal
   input  wire logic                 dem_in_in,      // demodulator input
   input  wire logic                 dem_shift_in,   // phase shifted signal
   input  wire logic                 dem_phase_in,   // phase detector output
   input  wire logic                 dem_out_in,     // demodulator output
   output logic                      synth_rst_out,  // synthesiser reset
   output logic      [3:0]           vco_gain_out,   // vco gain, lsb zero
   output logic      [4:0]           amp_gain_out,   // amplifier gain code
   output logic                      pump_polarity_out,     // charge pump polarity
   output logic      [1:0]           pump_current_code_out, // charge pump current
   output logic                      ref_osc_sleep_out,     // osc off in power down
   output logic      [3:0]           ref_div_out,           // reference divider
   output logic      [10:0]          fractional_counter_out,// signed counter
   output logic      [7:0]           deviation_out,         // d-counter
   output logic      [1:0]           amp_class_code_out,    // amplifier class
   output logic      [1:0]           shift_clock_source_out,// shift register clock
   output logic      [1:0]           if_select_out,         // if select
   output logic                      dem_test_en_out,       // if code 11 test modes
   output logic                      if_from_tx_out,        // if input from tx pin
   output logic      [7:0]           tuning_cap_en_out,     // thermometer cap steps
   output logic                      cap_array_en_out,      // capacitor array on
   output logic      [1:0]           amp_buffer_drive_out,  // buffer drive
   output logic                      lock_status_out,       // lock indication
   output logic                      lock_pin_out           // lock pin drive
);
   logic [WORD_W-1:0] gen_word, syn_word, frc_word, lck_word, dem_word;
   logic [WORD_W-1:0] next_gen_word, next_syn_word, next_frc_word;
   logic [WORD_W-1:0] next_lck_word, next_dem_word, next_rdata;
   logic              pll_written, next_pll_written;

   // ************************************************************
   // register access
   // ************************************************************
   always_comb begin
      next_gen_word = gen_word;
      next_syn_word = syn_word;
      next_frc_word = frc_word;
      next_lck_word = lck_word;
      next_dem_word = dem_word;
      next_pll_written = 1'b0;
      if (wr_in) begin
         unique case (addr_in)
            ADDR_GENERAL: next_gen_word = wdata_in;
            ADDR_SYNTH: begin
               next_syn_word    = wdata_in;
               next_pll_written = 1'b1;
            end
            ADDR_FRAC: begin
               next_frc_word    = wdata_in;
               next_pll_written = 1'b1;
            end
            ADDR_LOCK: begin
               next_lck_word    = wdata_in;
               next_pll_written = 1'b1;
            end
            ADDR_DEMOD: next_dem_word = wdata_in;
            default: ;
         endcase
      end
      next_rdata = '0;
      if (rd_in) begin
         unique case (addr_in)
            ADDR_GENERAL: next_rdata = gen_word;
            ADDR_SYNTH:   next_rdata = syn_word;
            ADDR_FRAC:    next_rdata = frc_word;
            ADDR_LOCK:    next_rdata = lck_word;
            ADDR_DEMOD:   next_rdata = dem_word;
            ADDR_STATUS:  next_rdata = {{(WORD_W-1){1'b0}}, lock_status_out};
            default:      next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gen_word    <= GENERAL_RESET;
         syn_word    <= SYNTH_RESET;
         frc_word    <= FRAC_RESET;
         lck_word    <= LOCK_RESET;
         dem_word    <= DEMOD_RESET;
         rdata_out   <= '0;
         pll_written <= 1'b0;
      end else begin
         gen_word    <= next_gen_word;
         syn_word    <= next_syn_word;
         frc_word    <= next_frc_word;
         lck_word    <= next_lck_word;
         dem_word    <= next_dem_word;
         rdata_out   <= next_rdata;
         pll_written <= next_pll_written;
      end
   end

   // ************************************************************
   // pin synchronisers and edge detection
   // ************************************************************
   logic [1:0] ref_sync, vco_sync, mon_sync, din_sync, dsh_sync, dph_sync, dout_sync;
   logic       ref_last, vco_last;
   logic       ref_edge, vco_edge;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_sync  <= '0;
         vco_sync  <= '0;
         mon_sync  <= '0;
         din_sync  <= '0;
         dsh_sync  <= '0;
         dph_sync  <= '0;
         dout_sync <= '0;
         ref_last  <= 1'b0;
         vco_last  <= 1'b0;
      end else begin
         ref_sync  <= {ref_sync[0], ref_clk_in};
         vco_sync  <= {vco_sync[0], vco_div_in};
         mon_sync  <= {mon_sync[0], synth_mon_in};
         din_sync  <= {din_sync[0], dem_in_in};
         dsh_sync  <= {dsh_sync[0], dem_shift_in};
         dph_sync  <= {dph_sync[0], dem_phase_in};
         dout_sync <= {dout_sync[0], dem_out_in};
         ref_last  <= ref_sync[1];
         vco_last  <= vco_sync[1];
      end
   end

   assign ref_edge = ref_sync[1] && !ref_last;
   assign vco_edge = vco_sync[1] && !vco_last;

   logic cmp_valid, cmp_ok;

   tspd_lock_detect u_lock_detect (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .ref_edge_in   (ref_edge),
      .vco_edge_in   (vco_edge),
      .wide_in       (lck_word[LCK_WIN_BIT]),
      .cmp_valid_out (cmp_valid),
      .cmp_ok_out    (cmp_ok)
   );

   // ************************************************************
   // lock indication
   // ************************************************************
   tspd_lock_state_t lock_state, next_lock_state;
   logic             next_lock_status;

   always_comb begin
      next_lock_state = lock_state;
      if (pll_written || syn_word[SYN_RESET_BIT]) begin
         next_lock_state = TSPD_UNLOCKED;
      end else begin
         unique case (lock_state)
            TSPD_UNLOCKED: begin
               if (cmp_valid && cmp_ok) begin
                  next_lock_state = lck_word[LCK_MODE_BIT] ? TSPD_TRACKING : TSPD_HELD;
               end
            end
            TSPD_HELD: begin
               if (lck_word[LCK_MODE_BIT]) begin
                  next_lock_state = TSPD_TRACKING;
               end
            end
            TSPD_TRACKING: begin
               if (!lck_word[LCK_MODE_BIT]) begin
                  next_lock_state = TSPD_HELD;
               end else if (cmp_valid && !cmp_ok) begin
                  next_lock_state = TSPD_UNLOCKED;
               end
            end
            default: next_lock_state = TSPD_UNLOCKED;
         endcase
      end
      // disabled detection forces the flag high regardless of the state
      next_lock_status = lck_word[LCK_DIS_BIT] || (next_lock_state != TSPD_UNLOCKED);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lock_state      <= TSPD_UNLOCKED;
         lock_status_out <= 1'b0;
      end else begin
         lock_state      <= next_lock_state;
         lock_status_out <= next_lock_status;
      end
   end

   // ************************************************************
   // decoded controls and lock pin routing
   // ************************************************************
   function automatic logic [7:0] therm(input logic [2:0] code);
      logic [7:0] t;
      t = '0;
      for (int i = 0; i < 8; i++) begin
         t[i] = (3'(i) < code);
      end
      return t;
   endfunction

   logic [2:0]  tdem;
   logic        next_lock_pin;
   logic        next_cap_en;

   assign tdem = dem_word[DEM_TST_HI:DEM_TST_LO];

   always_comb begin
      if (!tdem[2]) begin
         // normal mode shows lock, synth tests show their monitor signal
         next_lock_pin = (gen_word[GEN_S_HI:GEN_S_LO] == '0) ? next_lock_status
                                                             : mon_sync[1];
      end else begin
         unique case (tdem)
            TEST_DEM_INPUT: next_lock_pin = din_sync[1];
            TEST_DEM_SHIFT: next_lock_pin = dsh_sync[1];
            TEST_DEM_PHASE: next_lock_pin = dph_sync[1];
            default:        next_lock_pin = dout_sync[1];
         endcase
      end
      next_cap_en = (dem_word[DEM_INV_BIT] == gen_word[GEN_TX_BIT]);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         synth_rst_out          <= 1'b0;
         vco_gain_out           <= '0;
         amp_gain_out           <= '0;
         pump_polarity_out      <= 1'b0;
         pump_current_code_out  <= SYNTH_RESET[SYN_CHP_HI:SYN_CHP_LO];
         ref_osc_sleep_out      <= 1'b0;
         ref_div_out            <= '0;
         fractional_counter_out <= '0;
         deviation_out          <= '0;
         amp_class_code_out     <= '0;
         shift_clock_source_out <= '0;
         if_select_out          <= '0;
         dem_test_en_out        <= 1'b0;
         if_from_tx_out         <= 1'b0;
         tuning_cap_en_out      <= '0;
         cap_array_en_out       <= 1'b0;
         amp_buffer_drive_out   <= '0;
         lock_pin_out           <= 1'b0;
      end else begin
         synth_rst_out          <= syn_word[SYN_RESET_BIT];
         vco_gain_out           <= {syn_word[SYN_VCO_HI:SYN_VCO_LO], 1'b0};
         amp_gain_out           <= {syn_word[SYN_PA4_BIT], gen_word[GEN_PAM_HI:GEN_PAM_LO],
                                    frc_word[FRC_PA_HI:FRC_PA_LO]};
         pump_polarity_out      <= syn_word[SYN_POL_BIT];
         pump_current_code_out  <= syn_word[SYN_CHP_HI:SYN_CHP_LO];
         ref_osc_sleep_out      <= syn_word[SYN_OSC_BIT] && gen_word[GEN_PD_BIT];
         ref_div_out            <= syn_word[SYN_R_HI:0];
         fractional_counter_out <= frc_word[FRC_K_HI:0];
         deviation_out          <= lck_word[LCK_DEV_HI:0];
         amp_class_code_out     <= lck_word[LCK_CLS_HI:LCK_CLS_LO];
         shift_clock_source_out <= dem_word[DEM_CLK_HI:DEM_CLK_LO];
         if_select_out          <= dem_word[DEM_IF_HI:DEM_IF_LO];
         dem_test_en_out        <= (dem_word[DEM_IF_HI:DEM_IF_LO] == IF_TEST_CODE);
         if_from_tx_out         <= (tdem == TEST_DEM_OUT);
         tuning_cap_en_out      <= therm(dem_word[DEM_CAP_HI:DEM_CAP_LO]);
         cap_array_en_out       <= next_cap_en;
         amp_buffer_drive_out   <= dem_word[DEM_DRV_HI:0];
         lock_pin_out           <= next_lock_pin;
      end
   end
endmodule

// ===== core/tspd_pkg.sv
// package of offsets, field positions, reset values and timing for the transceiver config bank
// Function
// - synthesiser held in reset while reset bit is 1; bit resets to 0.
// - vco gain from 3-bit field with implied zero lsb; 000 max, 111 min.
// - amp gain top bit from synth word, low two bits from counter word.
// - amp gain middle bits 3:2 come from the general control word.
// - pump polarity bit: 0 adds charge when reference leads, 1 sinks.
// - pump current code 00/01/10/11 gives 10/20/40/80 uA; reset 10.
// - oscillator sleep bit 1 powers reference oscillator down during main power down.
// - fractional counter is 11-bit two's complement, top bit is sign.
// - lock window 21 ns when bit 0 (reset), 44 ns when 1.
// - lock mode bit 0 single shot, 1 continuous.
// - lock indication cleared whenever the pll settings are rewritten.
// - lock detect disable bit 1 forces lock status high.
// - amplifier class code 00 A, 01 AB, 10 B, 11 C.
// - shift clock source code picks external, crystal, 25 MHz or 12.5 MHz.
// - if select picks 60, 200, 455 kHz; code 11 enables test modes.
// - demod test top bit 0 routes lock pin per synth test field.
// - synth test field resets to 000, applies only when demod test top bit 0.
// - demod test codes 100/101/110 route input, shifted signal, detector to lock pin.
// - demod test code 111 drives demod output to lock pin, if input from tx pin.
// - tuning capacitance proportional to 3-bit code, 1.25 pF per step.
// - cap array active in receive when bit 0, in transmit when bit 1.
package tspd_pkg;
   localparam int unsigned WORD_W          = 13;
   localparam int unsigned ADDR_W          = 3;
   // word addresses follow the serial frame address codes
   localparam logic [2:0]  ADDR_GENERAL    = 3'h0;
   localparam logic [2:0]  ADDR_SYNTH      = 3'h2;
   localparam logic [2:0]  ADDR_FRAC       = 3'h3;
   localparam logic [2:0]  ADDR_LOCK       = 3'h4;
   localparam logic [2:0]  ADDR_DEMOD      = 3'h5;
   localparam logic [2:0]  ADDR_STATUS     = 3'h7;
   // reset values
   localparam logic [12:0] GENERAL_RESET   = 13'h0000;
   localparam logic [12:0] SYNTH_RESET     = 13'h0040;
   localparam logic [12:0] FRAC_RESET      = 13'h0000;
   localparam logic [12:0] LOCK_RESET      = 13'h0000;
   localparam logic [12:0] DEMOD_RESET     = 13'h0000;
   // field positions
   localparam int unsigned SYN_RESET_BIT   = 12;
   localparam int unsigned SYN_VCO_HI      = 11;
   localparam int unsigned SYN_VCO_LO      = 9;
   localparam int unsigned SYN_PA4_BIT     = 8;
   localparam int unsigned SYN_POL_BIT     = 7;
   localparam int unsigned SYN_CHP_HI      = 6;
   localparam int unsigned SYN_CHP_LO      = 5;
   localparam int unsigned SYN_OSC_BIT     = 4;
   localparam int unsigned SYN_R_HI        = 3;
   localparam int unsigned FRC_PA_HI       = 12;
   localparam int unsigned FRC_PA_LO       = 11;
   localparam int unsigned FRC_K_HI        = 10;
   localparam int unsigned LCK_WIN_BIT     = 12;
   localparam int unsigned LCK_MODE_BIT    = 11;
   localparam int unsigned LCK_DIS_BIT     = 10;
   localparam int unsigned LCK_CLS_HI      = 9;
   localparam int unsigned LCK_CLS_LO      = 8;
   localparam int unsigned LCK_DEV_HI      = 7;
   localparam int unsigned DEM_CLK_HI      = 12;
   localparam int unsigned DEM_CLK_LO      = 11;
   localparam int unsigned DEM_IF_HI       = 10;
   localparam int unsigned DEM_IF_LO       = 9;
   localparam int unsigned DEM_TST_HI      = 8;
   localparam int unsigned DEM_TST_LO      = 6;
   localparam int unsigned DEM_CAP_HI      = 5;
   localparam int unsigned DEM_CAP_LO      = 3;
   localparam int unsigned DEM_INV_BIT     = 2;
   localparam int unsigned DEM_DRV_HI      = 1;
   localparam int unsigned GEN_PD_BIT      = 12;
   localparam int unsigned GEN_TX_BIT      = 11;
   localparam int unsigned GEN_S_HI        = 10;
   localparam int unsigned GEN_S_LO        = 8;
   localparam int unsigned GEN_PAM_HI      = 7;
   localparam int unsigned GEN_PAM_LO      = 6;
   // lock window timing
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned LOCK_WIN_N_NS   = 21;
   localparam int unsigned LOCK_WIN_W_NS   = 44;
   localparam int unsigned LOCK_WIN_N_CYC  = LOCK_WIN_N_NS / CLK_PERIOD_NS;
   localparam int unsigned LOCK_WIN_W_CYC  = LOCK_WIN_W_NS / CLK_PERIOD_NS;
   localparam int unsigned WIN_CNT_W       = 4;
   // lock pin route codes, if test code and lock states
   localparam logic [2:0]  TEST_DEM_INPUT  = 3'h4;
   localparam logic [2:0]  TEST_DEM_SHIFT  = 3'h5;
   localparam logic [2:0]  TEST_DEM_PHASE  = 3'h6;
   localparam logic [2:0]  TEST_DEM_OUT    = 3'h7;
   localparam logic [1:0]  IF_TEST_CODE    = 2'h3;
   typedef enum logic [2:0] {
      TSPD_UNLOCKED = 3'b001,
      TSPD_HELD     = 3'b010,
      TSPD_TRACKING = 3'b100
   } tspd_lock_state_t;
endpackage

// ===== core/tspd_lock_detect.sv
// phase window comparator: flags each reference edge that lands within the window after the divided vco edge
`timescale 1ns/1ns
module tspd_lock_detect
   import tspd_pkg::*;
(
   input  wire logic clk_in,        // system clock
   input  wire logic rst_n_in,      // async reset, active low
   input  wire logic ref_edge_in,   // synchronised reference edge pulse
   input  wire logic vco_edge_in,   // synchronised divided oscillator edge pulse
   input  wire logic wide_in,       // lock window select
   output logic      cmp_valid_out, // one pulse per reference edge
   output logic      cmp_ok_out     // edges fell inside the window
);
   logic [WIN_CNT_W-1:0] since_vco;
   logic [WIN_CNT_W-1:0] next_since_vco;
   logic                 next_valid;
   logic                 next_ok;
   logic [WIN_CNT_W-1:0] win;

   always_comb begin
      // window limit rounds down so a marginal edge counts as unlocked
      win = wide_in ? WIN_CNT_W'(LOCK_WIN_W_CYC) : WIN_CNT_W'(LOCK_WIN_N_CYC);
      next_since_vco = since_vco;
      if (vco_edge_in) begin
         next_since_vco = '0;
      end else if (since_vco != '1) begin
         next_since_vco = since_vco + WIN_CNT_W'(1);
      end
      next_valid = ref_edge_in;
      next_ok    = ref_edge_in && (vco_edge_in || since_vco < win);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         since_vco     <= '1;
         cmp_valid_out <= 1'b0;
         cmp_ok_out    <= 1'b0;
      end else begin
         since_vco     <= next_since_vco;
         cmp_valid_out <= next_valid;
         cmp_ok_out    <= next_ok;
      end
   end
endmodule

// ===== bench/tspd_config_bank_checker.sv
// port assertions for the configuration word bank
`timescale 1ns/1ns
module tspd_config_bank_checker
   import tspd_pkg::*;
(
   input wire logic              clk_in,                // clock
   input wire logic              rst_n_in,              // reset, active low
   input wire logic [ADDR_W-1:0] addr_in,               // word address
   input wire logic [WORD_W-1:0] wdata_in,              // write data
   input wire logic              wr_in,                 // write strobe
   input wire logic              synth_rst_out,         // synth reset
   input wire logic [3:0]        vco_gain_out,          // vco gain
   input wire logic [4:0]        amp_gain_out,          // amp gain
   input wire logic              pump_polarity_out,     // pump polarity
   input wire logic [1:0]        pump_current_code_out, // pump current
   input wire logic [1:0]        amp_class_code_out,    // amp class
   input wire logic              dem_test_en_out,       // test modes
   input wire logic              if_from_tx_out,        // if from tx pin
   input wire logic [7:0]        tuning_cap_en_out,     // cap steps
   input wire logic              lock_status_out        // lock flag
);
   // ***********************************
   // write decodes and properties
   // ***********************************
   wire ws = wr_in && addr_in == ADDR_SYNTH;
   wire wf = wr_in && addr_in == ADDR_FRAC;
   wire wl = wr_in && addr_in == ADDR_LOCK;
   wire wd = wr_in && addr_in == ADDR_DEMOD;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_syn_rst; ws |-> ##2 synth_rst_out == $past(wdata_in[12], 2); endproperty
   a_syn_rst: assert property (p_syn_rst) else $error("synth reset out wrong");
   property p_vco; ws |-> ##2 vco_gain_out == {$past(wdata_in[11:9], 2), 1'b0}; endproperty
   a_vco: assert property (p_vco) else $error("vco gain wrong");
   property p_gain; wf |-> ##2 amp_gain_out[1:0] == $past(wdata_in[12:11], 2); endproperty
   a_gain: assert property (p_gain) else $error("amp gain low bits wrong");
   property p_pump; ws |-> ##2 {pump_polarity_out, pump_current_code_out} == $past(wdata_in[7:5], 2);
   endproperty
   a_pump: assert property (p_pump) else $error("pump settings wrong");
   property p_class; wl |-> ##2 amp_class_code_out == $past(wdata_in[9:8], 2); endproperty
   a_class: assert property (p_class) else $error("amp class wrong");
   property p_test; wd |-> ##2 dem_test_en_out == ($past(wdata_in[10:9], 2) == 2'h3); endproperty
   a_test: assert property (p_test) else $error("test enable wrong");
   property p_iftx; wd |-> ##2 if_from_tx_out == ($past(wdata_in[8:6], 2) == 3'h7); endproperty
   a_iftx: assert property (p_iftx) else $error("if source wrong");
   property p_cap;
      wd |-> ##2 tuning_cap_en_out == 8'((9'h001 << $past(wdata_in[5:3], 2)) - 9'h001);
   endproperty
   a_cap: assert property (p_cap) else $error("cap steps wrong");
   property p_dis; wl && wdata_in[10] |-> ##[2:4] lock_status_out; endproperty
   a_dis: assert property (p_dis) else $error("disabled lock not high");
   // two quiet cycles cover the two-cycle decode latency
   property p_hold; (!wr_in) [*2] |=> $stable(amp_class_code_out); endproperty
   a_hold: assert property (p_hold) else $error("class changed without write");
   c_lock: cover property ($rose(lock_status_out));
   c_tx: cover property (if_from_tx_out);
   c_syn: cover property (ws ##2 synth_rst_out);
endmodule
bind tspd_config_bank tspd_config_bank_checker u_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in,
   .wr_in, .synth_rst_out, .vco_gain_out, .amp_gain_out, .pump_polarity_out,
   .pump_current_code_out, .amp_class_code_out, .dem_test_en_out, .if_from_tx_out,
   .tuning_cap_en_out, .lock_status_out);

// ===== bench/tspd_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ns
module tspd_host_model
   import tspd_pkg::*;
(
   input  wire logic              clk_in,    // clock
   input  wire logic [WORD_W-1:0] rdata_in,  // read data
   output logic      [ADDR_W-1:0] addr_out,  // address
   output logic      [WORD_W-1:0] wdata_out, // write data
   output logic                   wr_out,    // write strobe
   output logic                   rd_out     // read strobe
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr_word(input logic [2:0] a, input logic [12:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   task automatic rd_word(input logic [2:0] a, output logic [12:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      @(negedge clk_in);
      d = rdata_in;
   endtask
   // negative counts are sent as two's complement of the 11-bit field
   task automatic wr_frac(input logic [1:0] g, input int k);
      wr_word(ADDR_FRAC, {g, 11'(k)});
   endtask
endmodule

// ===== bench/tspd_config_bank_tb_top.sv
// self-checking bench for the configuration word bank
`timescale 1ns/1ns
module tspd_config_bank_tb_top;
   import tspd_pkg::*;
   logic        clk_in, rst_n_in, ref_clk_in, vco_div_in, synth_mon_in, wr_in, rd_in;
   logic        synth_rst_out, pump_polarity_out, ref_osc_sleep_out, dem_test_en_out;
   logic        if_from_tx_out, cap_array_en_out, lock_status_out, lock_pin_out;
   logic [1:0]  pump_current_code_out, amp_class_code_out, shift_clock_source_out;
   logic [1:0]  if_select_out, amp_buffer_drive_out;
   logic [3:0]  vco_gain_out, ref_div_out, dsig;
   logic [4:0]  amp_gain_out;
   logic [7:0]  deviation_out, tuning_cap_en_out;
   logic [10:0] fractional_counter_out;
   logic [2:0]  addr_in, a;
   logic [12:0] wdata_in, rdata_out, rv;
   logic [12:0] w [8];
   logic [15:0] cn [6] = '{16'hbfff, 16'ha000, 16'h1800, 16'h5fff, 16'h8300, 16'h7800};
   int          failures = 0, checks_done = 0, ph = 0, vd = 0;
   wire  [55:0] obs = {synth_rst_out, vco_gain_out, amp_gain_out, pump_polarity_out,
      pump_current_code_out, ref_osc_sleep_out, ref_div_out, fractional_counter_out,
      deviation_out, amp_class_code_out, shift_clock_source_out, if_select_out,
      dem_test_en_out, if_from_tx_out, tuning_cap_en_out, cap_array_en_out, amp_buffer_drive_out};
   tspd_config_bank u_tspd_config_bank (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .ref_clk_in, .vco_div_in, .synth_mon_in, .dem_in_in(dsig[0]),
      .dem_shift_in(dsig[1]), .dem_phase_in(dsig[2]), .dem_out_in(dsig[3]), .synth_rst_out,
      .vco_gain_out, .amp_gain_out, .pump_polarity_out, .pump_current_code_out,
      .ref_osc_sleep_out, .ref_div_out, .fractional_counter_out, .deviation_out,
      .amp_class_code_out, .shift_clock_source_out, .if_select_out, .dem_test_en_out,
      .if_from_tx_out, .tuning_cap_en_out, .cap_array_en_out, .amp_buffer_drive_out,
      .lock_status_out, .lock_pin_out);
   tspd_host_model u_tspd_host_model (.clk_in, .rdata_in(rdata_out), .addr_out(addr_in),
      .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
   // ***********************************
   // helpers
   // ***********************************
   function automatic logic [55:0] expo();
      logic [12:0] g = w[0], s = w[2], f = w[3], l = w[4], m = w[5];
      return {s[12], s[11:9], 1'b0, s[8], g[7:6], f[12:11], s[7], s[6:5], s[4] & g[12], s[3:0],
         f[10:0], l[7:0], l[9:8], m[12:11], m[10:9], m[10:9] == 2'h3, m[8:6] == 3'h7,
         8'((9'h001 << m[5:3]) - 9'h001), m[2] == g[11], m[1:0]};
   endfunction
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic put(input logic [2:0] ad, input logic [12:0] d);
      u_tspd_host_model.wr_word(ad, d);
      if (ad inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5})
         w[ad] = d;
   endtask
   task automatic wait_lock(input logic e);
      repeat (2) @(negedge clk_in);
      for (int i = 0; i < 300 && lock_status_out !== e; i++)
         @(negedge clk_in);
      chk(lock_status_out, e);
      if (lock_status_out !== e)
         complete_run();
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // reference and divided phase: period 16, vco edge vd cycles after the reference edge
   always @(posedge clk_in) begin
      ph <= (ph + 1) % 16;
      ref_clk_in <= ph < 8;
      vco_div_in <= (ph - vd + 16) % 16 < 8;
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      failures++;
      complete_run();
   end
   initial begin
      rst_n_in = 1'b0;
      ref_clk_in = 1'b0;
      vco_div_in = 1'b0;
      synth_mon_in = 1'b0;
      dsig = 4'h0;
      w = '{default: 13'h0000};
      w[2] = 13'h0040;
      void'($urandom(32'hf9a4f0b0));
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      chk(obs, expo());
      for (int n = 0; n < 46; n++) begin
         a = n < 6 ? cn[n][15:13] : (n % 7 == 0 ? 3'h6 : 3'(n % 6));
         put(a, n < 6 ? cn[n][12:0] : 13'($urandom));
         repeat (3) @(negedge clk_in);
         chk(obs, expo());
         u_tspd_host_model.rd_word(a, rv);
         chk(rv, w[a]);
      end
      u_tspd_host_model.wr_frac(2'h1, -5);
      w[3] = {2'h1, 11'h7fb};
      repeat (3) @(negedge clk_in);
      chk(obs, expo());
      put(3'h2, 13'h0040);
      put(3'h4, 13'h0800);
      wait_lock(1'b1);
      vd = 13;
      wait_lock(1'b0);
      put(3'h4, 13'h1800);
      wait_lock(1'b1);
      put(3'h4, 13'h0000);
      vd = 0;
      wait_lock(1'b1);
      vd = 6;
      repeat (80) @(negedge clk_in);
      chk(lock_status_out, 1'b1);
      put(3'h2, 13'h0040);
      wait_lock(1'b0);
      put(3'h4, 13'h0400);
      wait_lock(1'b1);
      u_tspd_host_model.rd_word(3'h7, rv);
      chk(rv, 13'h0001);
      for (int k = 0; k < 6; k++) begin
         put(3'h0, k == 1 ? 13'h0100 : 13'h0000);
         put(3'h5, k < 2 ? 13'h0000 : 13'(k + 2) << 6);
         repeat (2) begin
            @(posedge clk_in);
            synth_mon_in <= 1'($urandom);
            dsig <= 4'($urandom);
            repeat (6) @(negedge clk_in);
            chk(lock_pin_out, k == 0 ? 1'b1 : k == 1 ? synth_mon_in : dsig[2'(k - 2)]);
         end
      end
      complete_run();
   end
endmodule
